/* hdl/mec_pkg.sv */
package mec_pkg;
  localparam logic [7:0] CFG_ADDR = 8'h20;
  localparam logic [7:0] STAT_ADDR = 8'h80;
  localparam logic [7:0] THR_ADDR = 8'h24;
  localparam logic [31:0] CFG_RESET = 32'h0030DA20;
  localparam int CFG_TEMP_BIT = 22;
  localparam int CFG_ZC_BIT = 21;
  localparam int CFG_CNT_LSB = 8;
  localparam int CFG_PH_LSB = 6;
  localparam int CFG_PULSE_BIT = 5;
  localparam int STAT_F0_BIT = 3;
  localparam logic [31:0] THR_RESET = 32'h00000000;

  typedef enum logic [1:0] {
    MEC_PH_A = 2'b00,
    MEC_PH_B = 2'b01,
    MEC_PH_C = 2'b10,
    MEC_PH_X = 2'b11
  } mec_phase_t;

  typedef struct packed {
    logic signed [31:0] va;
    logic signed [31:0] vb;
    logic signed [31:0] vc;
  } mec_samples_t;
endpackage

/* hdl/mec_engine.sv */
`timescale 1ns/1ns
module mec_engine #(
  parameter int CNT_W = 12
) (
  input wire logic clk, // 10 MHz clock
  input wire logic rstn, // Synchronous reset, active low
  input wire logic sample_valid, // One new sample set, one cycle
  input wire mec_pkg::mec_samples_t samples, // Phase voltages
  input wire logic [7:0] ram_addr, // Engine RAM word address
  input wire logic ram_wr, // Write strobe
  input wire logic [31:0] ram_wdata, // Write data
  output logic [31:0] ram_rdata, // Read data, registered
  output logic engine_busy, // One pulse per finished pass
  output logic zero_cross_pulse_output, // Zero crossing pulse
  output logic host_temperature_comp, // Host owns temperature comp
  output logic host_pulse_source // Host pulse rates in use
);
  logic [31:0] cfg_q, cfg_d;
  logic [31:0] thr_q, thr_d;
  logic [31:0] rd_q, rd_d;
  logic [3:0] stat_q, stat_d;
  logic [2:0] sag_q, sag_d;
  logic [CNT_W-1:0] cnt_q [3];
  logic [CNT_W-1:0] cnt_d [3];
  logic f0_q, f0_d;
  logic busy_q, busy_d;
  logic zc_q, zc_d;
  logic signed [31:0] v [3];
  logic signed [31:0] vsel;
  logic [CNT_W-1:0] need;
  mec_pkg::mec_phase_t ph;

  assign v[0] = samples.va;
  assign v[1] = samples.vb;
  assign v[2] = samples.vc;
  assign need = cfg_q[mec_pkg::CFG_CNT_LSB +: CNT_W];
  assign ph = mec_pkg::mec_phase_t'(cfg_q[mec_pkg::CFG_PH_LSB +: 2]);

  // Bit 23 is stored but never read by the engine.
  always_comb begin
    cfg_d = cfg_q;
    thr_d = thr_q;
    if (ram_wr && ram_addr == mec_pkg::CFG_ADDR) begin
      cfg_d = ram_wdata;
    end
    if (ram_wr && ram_addr == mec_pkg::THR_ADDR) begin
      thr_d = ram_wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      cfg_q <= mec_pkg::CFG_RESET;
      thr_q <= mec_pkg::THR_RESET;
    end else begin
      cfg_q <= cfg_d;
      thr_q <= thr_d;
    end
  end

  assign host_temperature_comp = cfg_q[mec_pkg::CFG_TEMP_BIT];
  assign host_pulse_source = cfg_q[mec_pkg::CFG_PULSE_BIT];

  // Sag counters: one per phase, saturating at the configured count.
  for (genvar i = 0; i < 3; i++) begin : g_sag
    always_comb begin
      cnt_d[i] = cnt_q[i];
      sag_d[i] = sag_q[i];
      if (sample_valid) begin
        if (v[i] < $signed(thr_q)) begin
          if (cnt_q[i] < need) begin
            cnt_d[i] = cnt_q[i] + 1'b1;
          end
          if (cnt_q[i] + 1'b1 >= need) begin
            sag_d[i] = 1'b1;
          end
        end else if (v[i] > $signed(thr_q)) begin
          cnt_d[i] = '0;
          sag_d[i] = 1'b0;
        end
      end
    end
    always_ff @(posedge clk) begin
      if (!rstn) begin
        cnt_q[i] <= '0;
        sag_q[i] <= 1'b0;
      end else begin
        cnt_q[i] <= cnt_d[i];
        sag_q[i] <= sag_d[i];
      end
    end
  end

  always_comb begin
    case (ph)
      mec_pkg::MEC_PH_A: vsel = v[0];
      mec_pkg::MEC_PH_B: vsel = v[1];
      mec_pkg::MEC_PH_C: vsel = v[2];
      default: vsel = v[0];
    endcase
  end

  always_comb begin
    f0_d = f0_q;
    zc_d = 1'b0;
    busy_d = sample_valid;
    stat_d = stat_q;
    rd_d = rd_q;
    if (sample_valid) begin
      f0_d = ~vsel[31];
      zc_d = cfg_q[mec_pkg::CFG_ZC_BIT] && (f0_d != f0_q);
    end
    if (busy_q) begin
      stat_d = {f0_q, sag_q};
    end
    case (ram_addr)
      mec_pkg::CFG_ADDR: rd_d = cfg_q;
      mec_pkg::THR_ADDR: rd_d = thr_q;
      mec_pkg::STAT_ADDR: rd_d = {28'h0000000, stat_q};
      default: rd_d = 32'h00000000;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      f0_q <= 1'b0;
      zc_q <= 1'b0;
      busy_q <= 1'b0;
      stat_q <= 4'h0;
      rd_q <= 32'h00000000;
    end else begin
      f0_q <= f0_d;
      zc_q <= zc_d;
      busy_q <= busy_d;
      stat_q <= stat_d;
      rd_q <= rd_d;
    end
  end

  assign ram_rdata = rd_q;
  assign engine_busy = busy_q;
  assign zero_cross_pulse_output = zc_q;

  // Status word and read path.
  a_status_update: assert property (
    @(posedge clk) disable iff (!rstn)
    busy_q |=> stat_q == {$past(f0_q), $past(sag_q)})
    else $error("status not loaded at pass end");

  a_status_hold: assert property (
    @(posedge clk) disable iff (!rstn)
    !busy_q |=> $stable(stat_q))
    else $error("status changed between passes");

  a_status_upper: assert property (
    @(posedge clk) disable iff (!rstn)
    $past(ram_addr) == mec_pkg::STAT_ADDR |-> ram_rdata[31:4] == '0)
    else $error("status upper bits not zero");

  a_status_read: assert property (
    @(posedge clk) disable iff (!rstn)
    $past(ram_addr) == mec_pkg::STAT_ADDR |->
    ram_rdata[3:0] == $past(stat_q))
    else $error("status read does not match status word");

  a_addr_unmapped: assert property (
    @(posedge clk) disable iff (!rstn)
    $past(ram_addr) != mec_pkg::CFG_ADDR &&
    $past(ram_addr) != mec_pkg::THR_ADDR &&
    $past(ram_addr) != mec_pkg::STAT_ADDR |-> ram_rdata == '0)
    else $error("unmapped address read not zero");

  a_busy_rate: assert property (
    @(posedge clk) disable iff (!rstn)
    sample_valid |=> engine_busy)
    else $error("busy pulse missing");

  a_busy_idle: assert property (
    @(posedge clk) disable iff (!rstn)
    !sample_valid |=> !engine_busy)
    else $error("busy pulse without a sample");

  a_f0_follow: assert property (
    @(posedge clk) disable iff (!rstn)
    sample_valid |=> f0_q == ~$past(vsel[31]))
    else $error("square wave does not follow phase sign");

  a_f0_hold: assert property (
    @(posedge clk) disable iff (!rstn)
    !sample_valid |=> $stable(f0_q))
    else $error("square wave moved without a sample");

  // Dip flags and counters.
  a_sag_rise: assert property (
    @(posedge clk) disable iff (!rstn)
    sample_valid && v[0] > $signed(thr_q) |=> !sag_q[0])
    else $error("phase A sag not cleared");

  a_sag_b_rise: assert property (
    @(posedge clk) disable iff (!rstn)
    sample_valid && v[1] > $signed(thr_q) |=> !sag_q[1])
    else $error("phase B sag not cleared");

  a_sag_c_rise: assert property (
    @(posedge clk) disable iff (!rstn)
    sample_valid && v[2] > $signed(thr_q) |=> !sag_q[2])
    else $error("phase C sag not cleared");

  a_sag_a_keep: assert property (
    @(posedge clk) disable iff (!rstn)
    sag_q[0] && !sample_valid |=> sag_q[0])
    else $error("phase A sag dropped");

  a_sag_b_keep: assert property (
    @(posedge clk) disable iff (!rstn)
    sag_q[1] && !sample_valid |=> sag_q[1])
    else $error("phase B sag dropped");

  a_sag_c_keep: assert property (
    @(posedge clk) disable iff (!rstn)
    sag_q[2] && !sample_valid |=> sag_q[2])
    else $error("phase C sag dropped");

  a_sag_a_set: assert property (
    @(posedge clk) disable iff (!rstn)
    $rose(sag_q[0]) |-> $past(v[0]) < $signed($past(thr_q)))
    else $error("phase A sag set without dip");

  a_sag_b_set: assert property (
    @(posedge clk) disable iff (!rstn)
    $rose(sag_q[1]) |-> $past(v[1]) < $signed($past(thr_q)))
    else $error("phase B sag set without dip");

  a_sag_c_set: assert property (
    @(posedge clk) disable iff (!rstn)
    $rose(sag_q[2]) |-> $past(v[2]) < $signed($past(thr_q)))
    else $error("phase C sag set without dip");

  a_sag_a_zero: assert property (
    @(posedge clk) disable iff (!rstn)
    sample_valid && v[0] < $signed(thr_q) && need == '0 |=> sag_q[0])
    else $error("phase A sag not set with zero count");

  a_sag_b_equal: assert property (
    @(posedge clk) disable iff (!rstn)
    sample_valid && v[1] == $signed(thr_q) && sag_q[1] |=> sag_q[1])
    else $error("phase B sag cleared at threshold");

  a_cnt_clear: assert property (
    @(posedge clk) disable iff (!rstn)
    sample_valid && v[0] > $signed(thr_q) |=> cnt_q[0] == '0)
    else $error("phase A dip count not cleared");

  a_cnt_step: assert property (
    @(posedge clk) disable iff (!rstn)
    sample_valid && v[1] < $signed(thr_q) && cnt_q[1] < need |=>
    cnt_q[1] == $past(cnt_q[1]) + 1'b1)
    else $error("phase B dip count did not step");

  a_cnt_idle: assert property (
    @(posedge clk) disable iff (!rstn)
    !sample_valid |=> $stable(cnt_q[2]))
    else $error("phase C dip count moved without a sample");

  // Zero crossing pulse.
  a_zc_off: assert property (
    @(posedge clk) disable iff (!rstn)
    !cfg_q[mec_pkg::CFG_ZC_BIT] |=> !zero_cross_pulse_output)
    else $error("zero crossing pulse while disabled");

  a_zc_edge: assert property (
    @(posedge clk) disable iff (!rstn)
    zero_cross_pulse_output |-> f0_q != $past(f0_q))
    else $error("zero crossing pulse without sign change");

  a_zc_quiet: assert property (
    @(posedge clk) disable iff (!rstn)
    !sample_valid |=> !zero_cross_pulse_output)
    else $error("zero crossing pulse without a sample");

  // Configuration and threshold words.
  a_cfg_write: assert property (
    @(posedge clk) disable iff (!rstn)
    ram_wr && ram_addr == mec_pkg::CFG_ADDR |=> cfg_q == $past(ram_wdata))
    else $error("config write lost");

  a_cfg_keep: assert property (
    @(posedge clk) disable iff (!rstn)
    !(ram_wr && ram_addr == mec_pkg::CFG_ADDR) |=> $stable(cfg_q))
    else $error("config changed without a write");

  a_cfg_read: assert property (
    @(posedge clk) disable iff (!rstn)
    $past(ram_addr) == mec_pkg::CFG_ADDR |-> ram_rdata == $past(cfg_q))
    else $error("config read does not match");

  a_thr_write: assert property (
    @(posedge clk) disable iff (!rstn)
    ram_wr && ram_addr == mec_pkg::THR_ADDR |=> thr_q == $past(ram_wdata))
    else $error("threshold write lost");

  a_temp_write: assert property (
    @(posedge clk) disable iff (!rstn)
    ram_wr && ram_addr == mec_pkg::CFG_ADDR |=>
    host_temperature_comp == $past(ram_wdata[mec_pkg::CFG_TEMP_BIT]))
    else $error("temperature owner not taken from config");

  a_pulse_write: assert property (
    @(posedge clk) disable iff (!rstn)
    ram_wr && ram_addr == mec_pkg::CFG_ADDR |=>
    host_pulse_source == $past(ram_wdata[mec_pkg::CFG_PULSE_BIT]))
    else $error("pulse source not taken from config");
endmodule

/* dv/mec_host_model.sv */
`timescale 1ns/1ns
module mec_host_model (
  input wire logic clk, // Engine clock
  input wire logic [31:0] ram_rdata, // Read data
  output logic [7:0] ram_addr, // Word address
  output logic ram_wr, // Write strobe
  output logic [31:0] ram_wdata // Write data
);
  initial begin
    ram_addr = 8'h00;
    ram_wr = 1'b0;
    ram_wdata = 32'h0;
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    ram_addr <= a;
    ram_wr <= 1'b1;
    ram_wdata <= d;
    @(posedge clk);
    ram_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    ram_addr <= a;
    repeat (2) @(posedge clk);
    #1 d = ram_rdata;
  endtask
endmodule

/* dv/test_metering_engine_status_config.sv */
`timescale 1ns/1ns
module test_metering_engine_status_config;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic sv = 1'b0;
  mec_pkg::mec_samples_t smp = '0;
  logic [7:0] addr;
  logic wr, busy, zc, tc, ps, f0p;
  logic [31:0] wd, rdata, d, cfg, st;
  logic signed [31:0] v[3];
  int err_total = 0;
  int samples_checked = 0;
  int cyc = 0;
  int cnt[3];
  mec_engine u_mec_engine (.clk(clk), .rstn(rstn), .sample_valid(sv),
    .samples(smp), .ram_addr(addr), .ram_wr(wr), .ram_wdata(wd),
    .ram_rdata(rdata), .engine_busy(busy), .zero_cross_pulse_output(zc),
    .host_temperature_comp(tc), .host_pulse_source(ps));
  mec_host_model u_mec_host_model (.clk(clk), .ram_rdata(rdata),
    .ram_addr(addr), .ram_wr(wr), .ram_wdata(wd));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected at %0t: %h vs %h", $time, seen, exp);
    end
  endtask
  task automatic test_done();
    $display("checks %0d errors %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial forever #50 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      err_total++;
      test_done();
    end
  end
  initial begin
    void'($urandom(32'h4e8a));
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    u_mec_host_model.rd(mec_pkg::CFG_ADDR, d);
    chk(d, mec_pkg::CFG_RESET);
    chk({tc, ps}, 2'b01);
    u_mec_host_model.wr(mec_pkg::STAT_ADDR, 32'hFFFFFFFF);
    st = 32'h0;
    f0p = 1'b0;
    cnt = '{0, 0, 0};
    for (int k = 0; k < 4; k++) begin
      cfg = {8'h00, 3'($urandom), 1'b1, 12'($urandom_range(0, 3)),
        2'($urandom_range(0, 2)), 1'($urandom), 5'h00};
      u_mec_host_model.wr(mec_pkg::CFG_ADDR, cfg);
      u_mec_host_model.wr(mec_pkg::THR_ADDR, 32'h0);
      u_mec_host_model.rd(mec_pkg::CFG_ADDR, d);
      chk(d, cfg);
      chk({tc, ps}, {cfg[22], cfg[5]});
      for (int j = 0; j < 20; j++) begin
        for (int p = 0; p < 3; p++) begin
          v[p] = (j == 0) ? 3 : int'($urandom_range(0, 6)) - 3;
          if (v[p] < 0) cnt[p]++;
          else if (v[p] > 0) cnt[p] = 0;
          st[p] = cnt[p] > 0 && cnt[p] >= int'(cfg[19:8]);
        end
        st[3] = v[cfg[7:6]] >= 0;
        @(posedge clk);
        sv <= 1'b1;
        smp <= {v[0], v[1], v[2]};
        @(posedge clk);
        sv <= 1'b0;
        #1;
        chk(busy, 1'b1);
        if (j > 0) chk(zc, cfg[21] & (st[3] ^ f0p));
        f0p = st[3];
        u_mec_host_model.rd(mec_pkg::STAT_ADDR, d);
        chk(d, st);
      end
    end
    test_done();
  end
endmodule
